//--- src/bis_pkg.sv
/*
 * constants, field positions and types shared by the backlight register block.
 * assumes a single 50 mhz system clock and an active-low asynchronous reset.
 */
package bis_pkg;

   // ************************************************************
   // register offsets as seen on the serial port
   // ************************************************************
   localparam logic [7:0] OFS_CONTROL     = 8'h00;
   localparam logic [7:0] OFS_CONFIG      = 8'h01;
   localparam logic [7:0] OFS_BOOST       = 8'h02;
   localparam logic [7:0] OFS_BRIGHT_A    = 8'h03;
   localparam logic [7:0] OFS_BRIGHT_B    = 8'h04;
   localparam logic [7:0] OFS_FULLSCALE_A = 8'h05;
   localparam logic [7:0] OFS_FULLSCALE_B = 8'h06;
   localparam logic [7:0] OFS_FILTER      = 8'h50;

   // ************************************************************
   // storage indices
   // ************************************************************
   localparam int          REG_COUNT       = 8;
   localparam int          IDX_W           = 3;
   localparam logic [2:0]  IDX_CONTROL     = 3'h0;
   localparam logic [2:0]  IDX_CONFIG      = 3'h1;
   localparam logic [2:0]  IDX_BOOST       = 3'h2;
   localparam logic [2:0]  IDX_BRIGHT_A    = 3'h3;
   localparam logic [2:0]  IDX_BRIGHT_B    = 3'h4;
   localparam logic [2:0]  IDX_FULLSCALE_A = 3'h5;
   localparam logic [2:0]  IDX_FULLSCALE_B = 3'h6;
   localparam logic [2:0]  IDX_FILTER      = 3'h7;
   localparam logic [7:0]  REG_RESET       = 8'h00;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int CTL_LINEAR_B   = 1;
   localparam int CTL_LINEAR_A   = 2;
   localparam int CTL_ENABLE_B   = 3;
   localparam int CTL_ENABLE_A   = 4;
   localparam int CFG_PWM_A      = 0;
   localparam int CFG_PWM_B      = 1;
   localparam int CFG_FB_A       = 3;
   localparam int CFG_FB_B       = 4;
   localparam int BST_FREQ       = 0;
   localparam int BST_OCP_LO     = 3;
   localparam int BST_OVP_LO     = 5;
   localparam int FS_HYST        = 7;
   localparam int FS_LOWER_BOUND = 6;
   localparam int FS_CODE_W      = 5;
   localparam int FLT_W          = 2;

   // ************************************************************
   // serial slave states
   // ************************************************************
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_AACK  = 3'b010,
      ST_WBYTE = 3'b011,
      ST_WACK  = 3'b100,
      ST_RBYTE = 3'b101,
      ST_RACK  = 3'b110
   } bis_state_type;

   localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
   localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h2a;

endpackage

//--- src/bis_pin_sync.sv
/*
 * three-flop input synchroniser with agreement filter, one lane per bit.
 * assumes asynchronous pin inputs and the system clock.
 */
module bis_pin_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level_q
);

   // ************************************************************
   // per-bit lanes
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_lane
         logic s1_q;
         logic s2_q;
         logic s3_q;
         always_ff @(posedge sys_clk or negedge resetn)
         begin
            if (!resetn)
            begin
               s1_q       <= RESET_VAL[g];
               s2_q       <= RESET_VAL[g];
               s3_q       <= RESET_VAL[g];
               level_q[g] <= RESET_VAL[g];
            end
            else
            begin
               s1_q <= pin_in[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q)
                  level_q[g] <= s3_q;
            end
         end
      end
   endgenerate

endmodule // bis_pin_sync

//--- src/bis_reg_mem.sv
/*
 * small register store with registered read port and a flat view of all entries.
 * assumes writes come from one master in the system clock domain.
 */
module bis_reg_mem
   import bis_pkg::*;
#(
   parameter int DEPTH = bis_pkg::REG_COUNT,
   parameter int WIDTH = 8
) (
   input  wire logic                     sys_clk,
   input  wire logic                     resetn,
   input  wire logic                     wr_en,
   input  wire logic [bis_pkg::IDX_W-1:0] wr_idx,
   input  wire logic [WIDTH-1:0]         wr_data,
   input  wire logic [bis_pkg::IDX_W-1:0] rd_idx,
   output logic      [WIDTH-1:0]         rd_data_q,
   output logic      [DEPTH*WIDTH-1:0]   contents_q
);
   import bis_pkg::*;

   // ************************************************************
   // storage entries
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : g_entry
         always_ff @(posedge sys_clk or negedge resetn)
         begin
            if (!resetn)
               contents_q[g*WIDTH +: WIDTH] <= WIDTH'(REG_RESET);
            else if (wr_en && (wr_idx == IDX_W'(g)))
               contents_q[g*WIDTH +: WIDTH] <= wr_data;
         end
      end
   endgenerate

   // ************************************************************
   // read port
   // ************************************************************
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         rd_data_q <= '0;
      else
         rd_data_q <= contents_q[rd_idx*WIDTH +: WIDTH];
   end

endmodule // bis_reg_mem

//--- src/bis_backlight_regs.sv
/*
 * backlight driver register block: serial slave, register store, decoded controls.
 * assumes scl, sda and pwm arrive asynchronously; sda is open drain outside.
 */
module bis_backlight_regs
   import bis_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = bis_pkg::DEFAULT_DEV_ADDR // arbitrary value
) (
   input  wire logic                             sys_clk,
   input  wire logic                             resetn,
   input  wire logic                             scl_in,
   input  wire logic                             sda_in,
   output logic                                  sda_out,
   output logic                                  sda_oe,
   input  wire logic                             pwm_in,
   output logic                                  bank_a_enable,
   output logic                                  bank_b_enable,
   output logic                                  bank_a_linear,
   output logic                                  bank_b_linear,
   output logic                                  bank_a_pwm_enable,
   output logic                                  bank_b_pwm_enable,
   output logic                                  bank_a_feedback,
   output logic                                  bank_b_feedback,
   output logic [1:0]                            overvoltage_limit_select,
   output logic [1:0]                            overcurrent_limit_select,
   output logic                                  switching_frequency_select,
   output logic [bis_pkg::FS_CODE_W-1:0]         bank_a_full_scale,
   output logic [bis_pkg::FS_CODE_W-1:0]         bank_b_full_scale,
   output logic                                  sampler_hysteresis_two,
   output logic                                  sampler_lower_bound_six,
   output logic [bis_pkg::FLT_W-1:0]             filter_strength,
   output logic [7:0]                            bank_a_level,
   output logic [7:0]                            bank_b_level
);
   import bis_pkg::*;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [2:0] pins_q;
   logic       scl_f;
   logic       sda_f;
   logic       pwm_f;

   bis_pin_sync #(
      .WIDTH     (3),
      .RESET_VAL (3'b011)
   ) u_sync (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .pin_in  ({pwm_in, sda_in, scl_in}),
      .level_q (pins_q)
   );

   assign scl_f = pins_q[0];
   assign sda_f = pins_q[1];
   assign pwm_f = pins_q[2];

   // ************************************************************
   // bus events
   // ************************************************************
   logic scl_p_q;
   logic sda_p_q;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end
      else
      begin
         scl_p_q <= scl_f;
         sda_p_q <= sda_f;
      end
   end

   assign scl_rise = scl_f & ~scl_p_q;
   assign scl_fall = ~scl_f & scl_p_q;
   assign start_ev = scl_f & scl_p_q & sda_p_q & ~sda_f;
   assign stop_ev  = scl_f & scl_p_q & ~sda_p_q & sda_f;

   // ************************************************************
   // offset decode
   // ************************************************************
   function automatic logic [IDX_W:0] decode_ofs(input logic [7:0] ofs);
      logic [IDX_W:0] r;
      r = '0;
      if (ofs == OFS_CONTROL)
         r = {1'b1, IDX_CONTROL};
      else if (ofs == OFS_CONFIG)
         r = {1'b1, IDX_CONFIG};
      else if (ofs == OFS_BOOST)
         r = {1'b1, IDX_BOOST};
      else if (ofs == OFS_BRIGHT_A)
         r = {1'b1, IDX_BRIGHT_A};
      else if (ofs == OFS_BRIGHT_B)
         r = {1'b1, IDX_BRIGHT_B};
      else if (ofs == OFS_FULLSCALE_A)
         r = {1'b1, IDX_FULLSCALE_A};
      else if (ofs == OFS_FULLSCALE_B)
         r = {1'b1, IDX_FULLSCALE_B};
      else if (ofs == OFS_FILTER)
         r = {1'b1, IDX_FILTER};
      return r;
   endfunction

   // ************************************************************
   // serial slave state
   // ************************************************************
   bis_state_type state_q;
   logic [3:0]    cnt_q;
   logic [7:0]    rx_q;
   logic [7:0]    tx_q;
   logic [7:0]    ptr_q;
   logic          first_q;
   logic          rw_q;
   logic          wr_en_q;
   logic [7:0]    wr_data_q;
   logic [IDX_W-1:0] wr_idx_q;
   logic [IDX_W:0]   ptr_dec;
   logic [7:0]       rd_data;
   logic [REG_COUNT*8-1:0] regs;

   assign ptr_dec = decode_ofs(ptr_q);

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q   <= ST_IDLE;
         cnt_q     <= '0;
         rx_q      <= '0;
         tx_q      <= '0;
         ptr_q     <= '0;
         first_q   <= 1'b0;
         rw_q      <= 1'b0;
         sda_oe    <= 1'b0;
         wr_en_q   <= 1'b0;
         wr_data_q <= '0;
         wr_idx_q  <= '0;
      end
      else
      begin
         wr_en_q <= 1'b0;
         if (stop_ev)
         begin
            state_q <= ST_IDLE;
            sda_oe  <= 1'b0;
         end
         else if (start_ev)
         begin
            state_q <= ST_ADDR;
            cnt_q   <= '0;
            sda_oe  <= 1'b0;
         end
         else
         begin
            case (state_q)
               ST_ADDR, ST_WBYTE:
               begin
                  if (scl_rise)
                  begin
                     rx_q  <= {rx_q[6:0], sda_f};
                     cnt_q <= cnt_q + 4'h1;
                  end
                  else if (scl_fall && (cnt_q == BIT_COUNT_FULL))
                  begin
                     if (state_q == ST_ADDR)
                     begin
                        if (rx_q[7:1] == DEV_ADDR)
                        begin
                           state_q <= ST_AACK;
                           rw_q    <= rx_q[0];
                           first_q <= 1'b1;
                           sda_oe  <= 1'b1;
                        end
                        else
                           state_q <= ST_IDLE;
                     end
                     else
                     begin
                        // first byte sets the pointer, later bytes store at mapped offsets and advance
                        state_q <= ST_WACK;
                        sda_oe  <= 1'b1;
                        first_q <= 1'b0;
                        if (first_q)
                           ptr_q <= rx_q;
                        else
                        begin
                           wr_en_q   <= ptr_dec[IDX_W];
                           wr_idx_q  <= ptr_dec[IDX_W-1:0];
                           wr_data_q <= rx_q;
                           ptr_q     <= ptr_q + 8'h01;
                        end
                     end
                  end
               end
               ST_AACK:
               begin
                  if (scl_fall)
                  begin
                     cnt_q <= '0;
                     if (rw_q)
                     begin
                        state_q <= ST_RBYTE;
                        tx_q    <= rd_data;
                        sda_oe  <= ~rd_data[7];
                     end
                     else
                     begin
                        state_q <= ST_WBYTE;
                        sda_oe  <= 1'b0;
                     end
                  end
               end
               ST_WACK:
               begin
                  if (scl_fall)
                  begin
                     state_q <= ST_WBYTE;
                     cnt_q   <= '0;
                     sda_oe  <= 1'b0;
                  end
               end
               ST_RBYTE:
               begin
                  if (scl_rise)
                     cnt_q <= cnt_q + 4'h1;
                  else if (scl_fall)
                  begin
                     if (cnt_q == BIT_COUNT_FULL)
                     begin
                        state_q <= ST_RACK;
                        sda_oe  <= 1'b0;
                     end
                     else
                     begin
                        tx_q   <= {tx_q[6:0], 1'b0};
                        sda_oe <= ~tx_q[6];
                     end
                  end
               end
               ST_RACK:
               begin
                  if (scl_rise)
                  begin
                     if (sda_f)
                        state_q <= ST_IDLE;
                     else
                        ptr_q <= ptr_q + 8'h01;
                  end
                  else if (scl_fall)
                  begin
                     state_q <= ST_RBYTE;
                     cnt_q   <= '0;
                     tx_q    <= rd_data;
                     sda_oe  <= ~rd_data[7];
                  end
               end
               default:
                  sda_oe <= 1'b0;
            endcase
         end
      end
   end

   // open-drain data line only ever pulls low
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         sda_out <= 1'b0;
      else
         sda_out <= 1'b0;
   end

   // ************************************************************
   // register store
   // ************************************************************
   logic [7:0] rd_word;

   bis_reg_mem #(
      .DEPTH (REG_COUNT),
      .WIDTH (8)
   ) u_mem (
      .sys_clk    (sys_clk),
      .resetn     (resetn),
      .wr_en      (wr_en_q),
      .wr_idx     (wr_idx_q),
      .wr_data    (wr_data_q),
      .rd_idx     (ptr_dec[IDX_W-1:0]),
      .rd_data_q  (rd_word),
      .contents_q (regs)
   );

   // unmapped offsets read as zero
   assign rd_data = ptr_dec[IDX_W] ? rd_word : 8'h00;

   // ************************************************************
   // decoded controls
   // ************************************************************
   logic [7:0] r_ctl;
   logic [7:0] r_cfg;
   logic [7:0] r_bst;
   logic [7:0] r_bra;
   logic [7:0] r_brb;
   logic [7:0] r_fsa;
   logic [7:0] r_fsb;
   logic [7:0] r_flt;

   assign r_ctl = regs[IDX_CONTROL*8 +: 8];
   assign r_cfg = regs[IDX_CONFIG*8 +: 8];
   assign r_bst = regs[IDX_BOOST*8 +: 8];
   assign r_bra = regs[IDX_BRIGHT_A*8 +: 8];
   assign r_brb = regs[IDX_BRIGHT_B*8 +: 8];
   assign r_fsa = regs[IDX_FULLSCALE_A*8 +: 8];
   assign r_fsb = regs[IDX_FULLSCALE_B*8 +: 8];
   assign r_flt = regs[IDX_FILTER*8 +: 8];

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bank_a_enable              <= 1'b0;
         bank_b_enable              <= 1'b0;
         bank_a_linear              <= 1'b0;
         bank_b_linear              <= 1'b0;
         bank_a_pwm_enable          <= 1'b0;
         bank_b_pwm_enable          <= 1'b0;
         bank_a_feedback            <= 1'b0;
         bank_b_feedback            <= 1'b0;
         overvoltage_limit_select   <= '0;
         overcurrent_limit_select   <= '0;
         switching_frequency_select <= 1'b0;
         bank_a_full_scale          <= '0;
         bank_b_full_scale          <= '0;
         sampler_hysteresis_two     <= 1'b0;
         sampler_lower_bound_six    <= 1'b0;
         filter_strength            <= '0;
      end
      else
      begin
         filter_strength            <= r_flt[FLT_W-1:0];
         bank_a_pwm_enable          <= r_cfg[CFG_PWM_A];
         bank_a_feedback            <= r_cfg[CFG_FB_A];
         bank_b_pwm_enable          <= r_cfg[CFG_PWM_B];
         bank_b_feedback            <= r_cfg[CFG_FB_B];
         overvoltage_limit_select   <= r_bst[BST_OVP_LO +: 2];
         overcurrent_limit_select   <= r_bst[BST_OCP_LO +: 2];
         switching_frequency_select <= r_bst[BST_FREQ];
         bank_a_full_scale          <= r_fsa[FS_CODE_W-1:0];
         bank_b_full_scale          <= r_fsb[FS_CODE_W-1:0];
         sampler_hysteresis_two     <= r_fsa[FS_HYST];
         sampler_lower_bound_six    <= ~r_fsa[FS_LOWER_BOUND];
         bank_a_enable              <= r_ctl[CTL_ENABLE_A];
         bank_b_enable              <= r_ctl[CTL_ENABLE_B];
         bank_a_linear              <= r_ctl[CTL_LINEAR_A];
         bank_b_linear              <= r_ctl[CTL_LINEAR_B];
      end
   end

   // ************************************************************
   // brightness levels, gated by enable and pwm input
   // ************************************************************
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bank_a_level <= '0;
         bank_b_level <= '0;
      end
      else
      begin
         bank_a_level <= (r_ctl[CTL_ENABLE_A] && (!r_cfg[CFG_PWM_A] || pwm_f)) ? r_bra : 8'h00;
         bank_b_level <= (r_ctl[CTL_ENABLE_B] && (!r_cfg[CFG_PWM_B] || pwm_f)) ? r_brb : 8'h00;
      end
   end

endmodule // bis_backlight_regs

//--- tb/bis_backlight_regs_properties.sv
/* port assertions for the backlight register block.
   assumes it is bound into the block and the data line has a pull-up. */
module bis_backlight_regs_properties
   import bis_pkg::*;
(
   input wire logic                          sys_clk,
   input wire logic                          resetn,
   input wire logic                          scl_in,
   input wire logic                          sda_in,
   input wire logic                          sda_oe,
   input wire logic                          pwm_in,
   input wire logic                          bank_a_enable,
   input wire logic                          bank_b_enable,
   input wire logic                          bank_a_pwm_enable,
   input wire logic                          bank_b_pwm_enable,
   input wire logic [1:0]                    overvoltage_limit_select,
   input wire logic [1:0]                    overcurrent_limit_select,
   input wire logic                          switching_frequency_select,
   input wire logic [bis_pkg::FS_CODE_W-1:0] bank_a_full_scale,
   input wire logic                          sampler_hysteresis_two,
   input wire logic                          sampler_lower_bound_six,
   input wire logic [7:0]                    bank_a_level,
   input wire logic [7:0]                    bank_b_level
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // properties
   // ****************************************
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   property p_off_a; !bank_a_enable [*3] |-> bank_a_level == 8'h00; endproperty
   a_off_a: assert property (p_off_a) else $error("level a while off");
   property p_off_b; !bank_b_enable [*3] |-> bank_b_level == 8'h00; endproperty
   a_off_b: assert property (p_off_b) else $error("level b while off");
   property p_pwm_a; (bank_a_pwm_enable && !pwm_in) [*8] |-> bank_a_level == 8'h00; endproperty
   a_pwm_a: assert property (p_pwm_a) else $error("level a with pwm low");
   property p_pwm_b; (bank_b_pwm_enable && !pwm_in) [*8] |-> bank_b_level == 8'h00; endproperty
   a_pwm_b: assert property (p_pwm_b) else $error("level b with pwm low");
   property p_oe; $changed(sda_oe) |-> !scl_in; endproperty
   a_oe: assert property (p_oe) else $error("data drive changed with clock high");
   property p_q_bst;
      (scl_in && sda_in) [*8] |=> $stable({overvoltage_limit_select,
         overcurrent_limit_select, switching_frequency_select});
   endproperty
   a_q_bst: assert property (p_q_bst) else $error("boost moved on idle bus");
   property p_q_fs;
      (scl_in && sda_in) [*8] |=> $stable({bank_a_full_scale, sampler_hysteresis_two,
         sampler_lower_bound_six});
   endproperty
   a_q_fs: assert property (p_q_fs) else $error("full scale moved on idle bus");
   property p_q_ctl;
      (scl_in && sda_in) [*8] |=> $stable({bank_a_enable, bank_b_enable,
         bank_a_pwm_enable, bank_b_pwm_enable});
   endproperty
   a_q_ctl: assert property (p_q_ctl) else $error("control moved on idle bus");

   c_full: cover property (bank_a_level == 8'hff);
   c_ack: cover property ($rose(sda_oe));
   c_gate: cover property (bank_a_pwm_enable && bank_a_enable && !pwm_in);
endmodule // bis_backlight_regs_properties

//--- tb/bis_host_model.sv
/* host model: serial master writing one register per transfer.
   assumes the bench resolves the open-drain data line with a pull-up. */
module bis_host_model (
   input  wire logic sys_clk,
   input  wire logic sda_bus,
   output logic      scl,
   output logic      sda_low
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // bus idle high, clock still between frames
   // ****************************************
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic hp();
      repeat (10) @(negedge sys_clk);
   endtask
   task automatic put(input logic [7:0] b, output logic a);
      for (int i = 7; i >= 0; i--)
      begin
         sda_low = ~b[i];
         hp();
         scl = 1'b1;
         hp();
         scl = 1'b0;
      end
      sda_low = 1'b0;
      hp();
      scl = 1'b1;
      a = ~sda_bus;
      hp();
      scl = 1'b0;
   endtask
   // single-byte write, next one only after stop
   task automatic wr(input logic [6:0] dev, input logic [7:0] off, d, output logic ok);
      logic a;
      sda_low = 1'b1;
      hp();
      scl = 1'b0;
      put({dev, 1'b0}, ok);
      if (ok)
      begin
         put(off, a);
         ok = ok & a;
         put(d, a);
         ok = ok & a;
      end
      sda_low = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      sda_low = 1'b0;
      hp();
   endtask
endmodule // bis_host_model

//--- tb/testbench.sv
/* self-checking bench for the backlight register block.
   assumes the host model and the port checker beside it. */
`define BIS_CHK(n, e, o) begin checked++; if ((o) !== (e)) begin fails++; \
   $display("MISMATCH %s expected %h seen %h", n, e, o); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import bis_pkg::*;
   typedef struct {int id; logic [7:0] e;} bis_note_type;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic pwm_in = 1'b1;
   logic scl_in, sda_low, sda_out, sda_oe, ok;
   wire  sda_in;
   logic bank_a_enable, bank_b_enable, bank_a_linear, bank_b_linear, bank_a_feedback;
   logic bank_a_pwm_enable, bank_b_pwm_enable, bank_b_feedback, switching_frequency_select;
   logic sampler_hysteresis_two, sampler_lower_bound_six;
   logic [1:0] overvoltage_limit_select, overcurrent_limit_select, filter_strength;
   logic [4:0] bank_a_full_scale, bank_b_full_scale;
   logic [7:0] bank_a_level, bank_b_level;
   logic [15:0] rs = 16'h24a9;
   int fails = 0;
   int checked = 0;
   bis_note_type q[$];
   event ev;
   string nm[9] = '{"filter", "config", "boost", "fs_a", "fs_b", "ctl", "lvl_a", "lvl_b", "ack"};
   initial forever #10 sys_clk = ~sys_clk;
   bis_backlight_regs i_bis_backlight_regs (.*);
   bis_host_model i_bis_host_model (.sys_clk(sys_clk), .sda_bus(sda_in), .scl(scl_in),
      .sda_low(sda_low));
   assign sda_in = !(sda_low || (sda_oe && !sda_out));
   // ****************************************
   // observed fields and helpers
   // ****************************************
   function automatic logic [7:0] obs(int id);
      case (id)
         0: return {6'h00, filter_strength};
         1: return {3'h0, bank_b_feedback, bank_a_feedback, 1'h0, bank_b_pwm_enable,
            bank_a_pwm_enable};
         2: return {1'h0, overvoltage_limit_select, overcurrent_limit_select, 2'h0,
            switching_frequency_select};
         3: return {sampler_hysteresis_two, ~sampler_lower_bound_six, 1'h0, bank_a_full_scale};
         4: return {3'h0, bank_b_full_scale};
         5: return {3'h0, bank_a_enable, bank_b_enable, bank_a_linear, bank_b_linear, 1'h0};
         6: return bank_a_level;
         7: return bank_b_level;
         default: return {7'h00, ok};
      endcase
   endfunction
   function automatic logic [7:0] rnd();
      rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
      return rs[7:0];
   endfunction
   task automatic note(int id, logic [7:0] e);
      q.push_back('{id, e});
   endtask
   task automatic wn(int id, logic [7:0] o, d, m);
      i_bis_host_model.wr(7'h2a, o, d, ok);
      note(id, d & m);
   endtask
   task automatic fin(string s);
      repeat (8) @(negedge sys_clk);
      -> ev;
      @(negedge sys_clk);
      $display("test %s done", s);
   endtask
   task automatic rst_chk(string s);
      resetn = 1'b0;
      repeat (5) @(negedge sys_clk);
      resetn = 1'b1;
      for (int i = 0; i < 8; i++)
         note(i, 8'h00);
      fin(s);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(ev)
   begin
      bis_note_type n;
      while (q.size() > 0)
      begin
         n = q.pop_front();
         `BIS_CHK(nm[n.id], n.e, obs(n.id))
      end
   end
   initial
   begin
      repeat (60000) @(posedge sys_clk);
      fails++;
      tally_and_finish();
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial
   begin
      logic [7:0] c, t, a, b, f;
      rst_chk("reset");
      wn(0, OFS_FILTER, 8'h03, 8'hff);
      wn(1, OFS_CONFIG, 8'h09, 8'hff);
      wn(2, OFS_BOOST, 8'h78, 8'hff);
      wn(3, OFS_FULLSCALE_A, 8'h94, 8'hff);
      wn(5, OFS_CONTROL, 8'h14, 8'hff);
      wn(6, OFS_BRIGHT_A, 8'hff, 8'hff);
      note(7, 8'h00);
      fin("init");
      pwm_in = 1'b0;
      note(6, 8'h00);
      fin("pwm gate");
      for (int k = 0; k < 4; k++)
      begin
         pwm_in = rs[9];
         wn(2, OFS_BOOST, rnd(), 8'h79);
         wn(3, OFS_FULLSCALE_A, rnd(), 8'hdf);
         wn(4, OFS_FULLSCALE_B, rnd(), 8'h1f);
         c = rnd();
         wn(1, OFS_CONFIG, c, 8'h1b);
         f = rnd();
         wn(0, OFS_FILTER, f, 8'h03);
         t = rnd();
         wn(5, OFS_CONTROL, t, 8'h1e);
         a = rnd();
         b = rnd();
         i_bis_host_model.wr(7'h2a, OFS_BRIGHT_A, a, ok);
         i_bis_host_model.wr(7'h2a, OFS_BRIGHT_B, b, ok);
         i_bis_host_model.wr(7'h2a, 8'h07, rnd(), ok);
         note(6, (t[4] && (!c[0] || pwm_in)) ? a : 8'h00);
         note(7, (t[3] && (!c[1] || pwm_in)) ? b : 8'h00);
         fin("random");
      end
      i_bis_host_model.wr(7'h2b, OFS_FILTER, ~f, ok);
      note(8, 8'h00);
      note(0, f & 8'h03);
      fin("wrong address");
      rst_chk("second reset");
      tally_and_finish();
   end
endmodule // testbench
bind bis_backlight_regs bis_backlight_regs_properties i_props (.*);
